/* File: design/sram_region_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module sram_region_decode
    import sram_cfg_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        REQ,
    input  wire logic        MST_DMA,
    input  wire logic        WE,
    input  wire logic [1:0]  SIZE,
    input  wire logic [31:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        EXCL,
    input  wire logic        ISRAM_EN,
    input  wire logic        CACHE_EN,
    input  wire logic        PARITY_EN,
    input  wire logic [1:0]  HIB_RET,
    input  wire logic        PAR_FLAG_CLR,
    output logic             RESP_VALID,
    output logic             RESP_ERR,
    output logic             RESP_EXOKAY,
    output logic [31:0]      RESP_RDATA,
    output logic             PAR_ERR,
    output logic             PAR_FLAG,
    output logic             CODE_FWD,
    output logic             SYS_FWD,
    output logic [7:0]       RET_KEEP
);
    logic              misal, in_code, in_sram, in_ppb, in_sys;
    logic              hit_dlo, hit_dhi, hit_inst, hit, is_excl_st;
    logic              mon_pass, mem_en, mem_we;
    logic [3:0]        be;
    logic [MEM_AW-1:0] idx;
    logic              valid_q, valid_d, err_q, err_d, exok_q, exok_d;
    logic              code_q, code_d, sys_q, sys_d, pflag_q, pflag_d;
    logic              mon_v_q, mon_v_d, mon_id_q, mon_id_d;
    logic [29:0]       mon_a_q, mon_a_d;
    logic [7:0]        ret_q, ret_d;
    logic [31:0]       mem_rdata;
    logic              mem_perr;

    // address decode and lane selection
    always_comb begin
        be = 4'h0;
        unique case (SIZE)
            SZ_BYTE: be = 4'h1 << ADDR[1:0];
            SZ_HALF: be = ADDR[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
        misal = (SIZE == SZ_HALF && ADDR[0])
             || (SIZE == SZ_WORD && ADDR[1:0] != 2'h0)
             || (SIZE == 2'h3);
        in_code = ADDR <= CODE_END;
        in_sram = ADDR >= SRAM_BASE && ADDR <= SRAM_END;
        in_ppb  = ADDR >= PPB_BASE && ADDR < PPB_END;
        in_sys  = ADDR >= PPB_BASE && ADDR <= SYS_END;
        hit_dlo = ADDR[31:BANK_LSB] == DSRAM_BASE[31:BANK_LSB];
        // the lent bank appears as data only while instruction sram is off
        hit_dhi = ADDR[31:BANK_LSB] == DSRAM_X_BASE[31:BANK_LSB]
               && !ISRAM_EN;
        hit_inst = ADDR[31:BANK_LSB] == ISRAM_BASE[31:BANK_LSB] && ISRAM_EN
                && !(CACHE_EN
                     && ADDR[BANK_LSB-1:CACHE_LSB] == CACHE_SLICE);
        hit = (hit_dlo || hit_dhi || hit_inst) && !misal;
        idx = {!hit_dlo, ADDR[BANK_LSB-1:2]};
        is_excl_st = EXCL && WE;
        mon_pass = mon_v_q && mon_id_q == MST_DMA
                && mon_a_q == ADDR[31:2];
        mem_en = REQ && hit && !(is_excl_st && !mon_pass);
        mem_we = WE;
    end

    // one-cycle response, no wait state for any master
    always_comb begin
        // a misaligned core access to the system region still needs an answer
        valid_d = REQ
               && !((in_code || (in_sys && !MST_DMA)) && !misal);
        err_d   = REQ && (misal || (in_ppb && MST_DMA)
                || !(hit || in_code || in_sys));
        exok_d  = REQ && EXCL && hit && (!WE || mon_pass);
        code_d  = REQ && in_code && !misal;
        sys_d   = REQ && in_sys && !MST_DMA && !misal;
        // a mismatch in the same cycle as a clear still sets the flag
        pflag_d = (pflag_q && !PAR_FLAG_CLR) || (valid_q && mem_perr);
    end

    // global exclusive monitor, one reservation for both masters
    always_comb begin
        mon_v_d  = mon_v_q;
        mon_id_d = mon_id_q;
        mon_a_d  = mon_a_q;
        if (REQ && hit) begin
            if (EXCL && !WE) begin
                mon_v_d  = 1'b1;
                mon_id_d = MST_DMA;
                mon_a_d  = ADDR[31:2];
            end else if (is_excl_st) begin
                mon_v_d  = 1'b0;
            end else if (WE && mon_a_q == ADDR[31:2]) begin
                mon_v_d  = 1'b0;
            end
        end
    end

    // retained segments, eight of 8 KB; the first data segment always kept
    always_comb begin
        ret_d = RET_FIXED;
        if (HIB_RET[0]) begin
            ret_d = ret_d | RET_DATA_X;
        end
        if (HIB_RET[1]) begin
            ret_d = ret_d | RET_INST_X;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            valid_q  <= 1'b0;
            err_q    <= 1'b0;
            exok_q   <= 1'b0;
            code_q   <= 1'b0;
            sys_q    <= 1'b0;
            pflag_q  <= 1'b0;
            mon_v_q  <= 1'b0;
            mon_id_q <= 1'b0;
            mon_a_q  <= 30'h0000_0000;
            ret_q    <= RET_FIXED;
        end else begin
            valid_q  <= valid_d;
            err_q    <= err_d;
            exok_q   <= exok_d;
            code_q   <= code_d;
            sys_q    <= sys_d;
            pflag_q  <= pflag_d;
            mon_v_q  <= mon_v_d;
            mon_id_q <= mon_id_d;
            mon_a_q  <= mon_a_d;
            ret_q    <= ret_d;
        end
    end

    sram_word_mem #(
        .WORDS (MEM_WORDS),
        .AW    (MEM_AW)
    ) u_mem (
        .clk     (CORE_CLK),
        .en      (mem_en),
        .we      (mem_we),
        .be      (be),
        .addr    (idx),
        .wdata   (WDATA),
        .par_en  (PARITY_EN),
        .rdata_q (mem_rdata),
        .perr_q  (mem_perr)
    );

    assign RESP_VALID  = valid_q;
    assign RESP_ERR    = err_q;
    assign RESP_EXOKAY = exok_q;
    assign RESP_RDATA  = mem_rdata;
    assign PAR_ERR     = mem_perr;
    assign PAR_FLAG    = pflag_q;
    assign CODE_FWD    = code_q;
    assign SYS_FWD     = sys_q;
    assign RET_KEEP    = ret_q;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    chk_code_route: assert property (
        REQ && ADDR <= CODE_END && SIZE == SZ_BYTE |=> CODE_FWD && !RESP_VALID)
        else $error("code access not forwarded");
    chk_sram_serve: assert property (
        REQ && ADDR[31:15] == DSRAM_BASE[31:15] && SIZE == SZ_BYTE
        |=> RESP_VALID && !RESP_ERR)
        else $error("data sram access not served");
    chk_bank_split: assert property (
        REQ && ISRAM_EN && ADDR[31:15] == DSRAM_X_BASE[31:15]
        |=> RESP_VALID && RESP_ERR)
        else $error("lent bank visible as data while in code use");
    chk_no_wait: assert property (
        REQ && ADDR >= SRAM_BASE && ADDR <= SRAM_END |=> RESP_VALID)
        else $error("sram access took a wait state");
    chk_dma_serve: assert property (
        REQ && MST_DMA && WE && ADDR[31:15] == DSRAM_BASE[31:15]
        && SIZE == SZ_WORD && ADDR[1:0] == 2'h0 |=> !RESP_ERR)
        else $error("dma write to data sram refused");
    chk_excl_fail: assert property (
        REQ && EXCL && WE && !mon_v_q && ADDR >= SRAM_BASE
        && ADDR <= SRAM_END |=> RESP_VALID && !RESP_EXOKAY)
        else $error("exclusive store passed without reservation");
    chk_ppb_dma: assert property (
        REQ && MST_DMA && ADDR >= PPB_BASE && ADDR < PPB_END
        |=> RESP_VALID && RESP_ERR && !SYS_FWD)
        else $error("dma reached private peripheral space");
    chk_half_align: assert property (
        REQ && SIZE == SZ_HALF && ADDR[0] |=> RESP_ERR)
        else $error("misaligned half word accepted");
    chk_ext_data: assert property (
        REQ && !ISRAM_EN && ADDR[31:15] == DSRAM_X_BASE[31:15]
        && SIZE == SZ_BYTE |=> !RESP_ERR)
        else $error("lent bank not mapped as data");
    chk_par_off: assert property (
        !PARITY_EN |=> !PAR_ERR)
        else $error("parity error with checking off");
    chk_cache_hole: assert property (
        REQ && ISRAM_EN && CACHE_EN && ADDR[31:15] == ISRAM_BASE[31:15]
        && ADDR[14:12] == CACHE_SLICE |=> RESP_ERR)
        else $error("cache slice addressable");
    chk_ret_fixed: assert property (
        ##1 RET_KEEP[0] && RET_KEEP[3:2] == 2'h0)
        else $error("fixed retention segment dropped");
    chk_ret_inst: assert property (
        HIB_RET == 2'h2 |=> RET_KEEP == 8'h31)
        else $error("instruction retention wrong");
    chk_par_flag: assert property (
        RESP_VALID && PAR_ERR
        |=> PAR_FLAG ##1 (PAR_FLAG || $past(PAR_FLAG_CLR)))
        else $error("parity flag not held");

    cov_excl_ok: cover property (REQ && EXCL && !WE ##1 REQ && EXCL && WE
                                 ##1 RESP_EXOKAY);
    cov_dma_read: cover property (REQ && MST_DMA && !WE && hit ##1 RESP_VALID);
    cov_ext_bank: cover property (REQ && hit_dhi ##1 RESP_VALID);
    cov_code: cover property (CODE_FWD);
endmodule
`default_nettype wire

/* File: pkg/sram_cfg_pkg.sv */
`default_nettype none
package sram_cfg_pkg;
    // code region, routed to the flash and cache resources
    localparam logic [31:0] CODE_BASE    = 32'h0000_0000;
    localparam logic [31:0] CODE_END     = 32'h0003_FFFF;
    // sram region decoded by this block
    localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
    localparam logic [31:0] SRAM_END     = 32'h2004_7FFF;
    // fixed 32 KB data bank and the 32 KB bank lent by instruction sram
    localparam logic [31:0] DSRAM_BASE   = 32'h2000_0000;
    localparam logic [31:0] DSRAM_X_BASE = 32'h2000_8000;
    // code-side window of the instruction bank
    localparam logic [31:0] ISRAM_BASE   = 32'h1000_0000;
    // processor-private peripheral space, core only
    localparam logic [31:0] PPB_BASE     = 32'hE000_0000;
    localparam logic [31:0] PPB_END      = 32'hE004_0000;
    localparam logic [31:0] SYS_END      = 32'hF7FF_FFFF;
    // 32 KB bank select bits and 4 KB cache slice at the top of the bank
    localparam int          BANK_LSB     = 15;
    localparam int          CACHE_LSB    = 12;
    localparam logic [2:0]  CACHE_SLICE  = 3'h7;
    // 256 32-bit words per KB, 64 KB in all
    localparam int          MEM_WORDS    = 16384;
    localparam int          MEM_AW       = 14;
    localparam int          RET_SEGS     = 8;
    // transfer sizes
    localparam logic [1:0]  SZ_BYTE      = 2'h0;
    localparam logic [1:0]  SZ_HALF      = 2'h1;
    localparam logic [1:0]  SZ_WORD      = 2'h2;
    // retention: segment 0 always, 1 extra data, 4 and 5 extra instruction
    localparam logic [7:0]  RET_FIXED    = 8'h01;
    localparam logic [7:0]  RET_DATA_X   = 8'h02;
    localparam logic [7:0]  RET_INST_X   = 8'h30;
endpackage
`default_nettype wire

/* File: design/sram_word_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module sram_word_mem
    import sram_cfg_pkg::*;
#(
    parameter int WORDS = MEM_WORDS,
    parameter int AW    = MEM_AW
) (
    input  wire logic          clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [3:0]    be,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          par_en,
    output logic      [31:0]   rdata_q,
    output logic               perr_q
);
    // two parity bits per word, one over each half word
    logic [33:0] mem [WORDS];
    logic [31:0] merged;
    logic [33:0] cur;
    logic [1:0]  par_calc;
    logic        perr_d;

    always_comb begin
        cur = mem[addr];
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : cur[i*8 +: 8];
        end
        par_calc = {^cur[31:16], ^cur[15:0]};
        perr_d = en && !we && par_en && (par_calc != cur[33:32]);
    end

    // parity is always written so that enabling checking later is safe
    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= {^merged[31:16], ^merged[15:0], merged};
        end
        if (en && !we) begin
            rdata_q <= cur[31:0];
        end
        perr_q <= perr_d;
    end
endmodule
`default_nettype wire

/* File: tb/bus_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// core or dma master: one transfer per edge, lines turn over while idle
// so that a stale address or data word never passes for a live one
module bus_master_model (
    input  wire logic        clk,
    output logic             req,
    output logic             dma,
    output logic             we,
    output logic [1:0]       sz,
    output logic [31:0]      addr,
    output logic [31:0]      wdata,
    output logic             excl
);
    initial begin
        req   = 1'b0;
        dma   = 1'b0;
        we    = 1'b0;
        sz    = 2'h0;
        addr  = 32'h0000_0000;
        wdata = 32'h0000_0000;
        excl  = 1'b0;
    end

    task automatic put(input logic m, w, input logic [1:0] s,
                       input logic [31:0] a, d, input logic x);
        @(negedge clk);
        req   = 1'b1;
        dma   = m;
        we    = w;
        sz    = s;
        addr  = a;
        wdata = d;
        excl  = x;
    endtask

    task automatic idle();
        @(negedge clk);
        req   = 1'b0;
        addr  = ~addr;
        wdata = ~wdata;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_sram_region_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module test_sram_region_decode
    import sram_cfg_pkg::*;
;
    typedef struct packed {
        logic [2:0]  kind;
        logic        err;
        logic        ok;
        logic        rd;
        logic [31:0] data;
        logic [63:0] t;
    } note_t;
    localparam logic [2:0]  K_RSP      = 3'h4;
    localparam logic [2:0]  K_CODE     = 3'h2;
    localparam logic [2:0]  K_SYS      = 3'h1;
    localparam logic [7:0]  RET_TAB[4] = '{8'h01, 8'h03, 8'h31, 8'h33};
    localparam logic [31:0] WADR[4]    = '{32'h2000_0000, 32'h2000_7FFC,
                                           32'h2000_8000, 32'h2000_FFFC};
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        isram_en = 1'b0;
    logic        cache_en = 1'b0;
    logic        parity_en = 1'b0;
    logic        par_clr = 1'b0;
    logic [1:0]  hib_ret = 2'h0;
    logic        req, dma, we, excl, resp_valid, resp_err, resp_exokay;
    logic        par_err, par_flag, code_fwd, sys_fwd;
    logic [1:0]  sz, s;
    logic [31:0] addr, wdata, resp_rdata, a;
    logic [7:0]  ret_keep;
    logic [31:0] mem[logic [31:0]];
    note_t       notes[$];
    note_t       n;
    int          n_errors = 0;
    int          num_checks = 0;

    always #5 core_clk = ~core_clk;

    bus_master_model u_bus_master_model (.clk(core_clk), .req(req),
        .dma(dma), .we(we), .sz(sz), .addr(addr), .wdata(wdata),
        .excl(excl));

    sram_region_decode u_sram_region_decode (.CORE_CLK(core_clk),
        .RSTN(rstn), .REQ(req), .MST_DMA(dma), .WE(we), .SIZE(sz),
        .ADDR(addr), .WDATA(wdata), .EXCL(excl), .ISRAM_EN(isram_en),
        .CACHE_EN(cache_en), .PARITY_EN(parity_en), .HIB_RET(hib_ret),
        .PAR_FLAG_CLR(par_clr), .RESP_VALID(resp_valid),
        .RESP_ERR(resp_err), .RESP_EXOKAY(resp_exokay),
        .RESP_RDATA(resp_rdata), .PAR_ERR(par_err), .PAR_FLAG(par_flag),
        .CODE_FWD(code_fwd), .SYS_FWD(sys_fwd), .RET_KEEP(ret_keep));

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fin(input string name);
        u_bus_master_model.idle();
        repeat (2) @(negedge core_clk);
        $display("test %s done", name);
    endtask

    // one transfer; the expected answer is noted and the word model updated
    task automatic acc(input logic m, w, input logic [1:0] z,
                       input logic [31:0] ad, d, input logic x,
                       input logic [2:0] k, input logic er, ok);
        note_t       e;
        logic [31:0] wd;
        logic [3:0]  be;
        u_bus_master_model.put(m, w, z, ad, d, x);
        wd = mem.exists(ad & ~32'h3) ? mem[ad & ~32'h3] : 32'h0000_0000;
        e.kind = k;
        e.err = er;
        e.ok = ok;
        e.rd = !w && k == K_RSP && !er;
        e.data = wd;
        e.t = $time + 10;
        notes.push_back(e);
        be = (z == SZ_WORD) ? 4'hF : (z == SZ_HALF) ?
             4'(4'h3 << {ad[1], 1'b0}) : 4'(4'h1 << ad[1:0]);
        if (w && k == K_RSP && !er && (!x || ok)) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) wd[8*i+:8] = d[8*i+:8];
            end
            mem[ad & ~32'h3] = wd;
        end
    endtask

    always @(negedge core_clk) begin
        if (rstn && (resp_valid || code_fwd || sys_fwd)) begin
            n = notes.size() > 0 ? notes.pop_front() : '0;
            check(32'({resp_valid, code_fwd, sys_fwd}), 32'(n.kind));
            check(32'($time - n.t), 32'h0000_0000);
            if (resp_valid) begin
                check(32'(resp_err), 32'(n.err));
                check(32'(resp_exokay), 32'(n.ok));
            end
            if (resp_valid && n.rd) begin
                check(resp_rdata, n.data);
                check(32'(par_err), 32'h0000_0000);
            end
        end
    end

    initial begin
        #100000;
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(32'h5268));
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        check(32'(ret_keep), 32'h0000_0001);
        check(32'(par_flag), 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            hib_ret = 2'(i);
            @(negedge core_clk);
            check(32'(ret_keep), 32'(RET_TAB[i]));
        end
        fin("retention");
        for (int i = 0; i < 8; i++) begin
            acc(i[0], 1'(i < 4), SZ_WORD, WADR[i % 4], $urandom(), '0,
                K_RSP, '0, '0);
        end
        fin("words");
        acc('0, '1, SZ_WORD, 32'h2000_0010, $urandom(), '0, K_RSP, '0, '0);
        for (int i = 0; i < 8; i++) begin
            s = 2'($urandom_range(1));
            a = 32'h2000_0010 | (32'($urandom_range(3)) & ~32'(s));
            acc(i[0], '1, s, a, $urandom(), '0, K_RSP, '0, '0);
            acc(i[1], '0, SZ_WORD, 32'h2000_0010, '0, '0, K_RSP, '0, '0);
        end
        fin("lanes");
        a = 32'h2000_0020;
        acc('0, '1, SZ_WORD, a, $urandom(), '0, K_RSP, '0, '0);
        acc('0, '0, SZ_WORD, a, '0, '1, K_RSP, '0, '1);
        acc('0, '1, SZ_WORD, a, $urandom(), '1, K_RSP, '0, '1);
        acc('0, '1, SZ_WORD, a, $urandom(), '1, K_RSP, '0, '0);
        acc('1, '0, SZ_WORD, a, '0, '1, K_RSP, '0, '1);
        acc('0, '1, SZ_WORD, a, $urandom(), '1, K_RSP, '0, '0);
        acc('0, '0, SZ_WORD, a, '0, '1, K_RSP, '0, '1);
        acc('1, '1, SZ_WORD, a, $urandom(), '0, K_RSP, '0, '0);
        acc('0, '1, SZ_WORD, a, $urandom(), '1, K_RSP, '0, '0);
        acc('0, '0, SZ_WORD, a, '0, '0, K_RSP, '0, '0);
        fin("exclusive");
        isram_en = 1'b1;
        cache_en = 1'b1;
        acc('0, '1, SZ_WORD, 32'h2000_8000, '1, '0, K_RSP, '1, '0);
        acc('0, '1, SZ_WORD, 32'h1000_6FFC, $urandom(), '0, K_RSP, '0, '0);
        acc('1, '0, SZ_WORD, 32'h1000_6FFC, '0, '0, K_RSP, '0, '0);
        acc('0, '0, SZ_WORD, 32'h1000_7000, '0, '0, K_RSP, '1, '0);
        acc('1, '0, SZ_WORD, 32'hE000_0000, '0, '0, K_RSP, '1, '0);
        acc('1, '1, SZ_WORD, 32'hE003_FFFC, '0, '0, K_RSP, '1, '0);
        acc('0, '0, SZ_WORD, 32'hE000_0000, '0, '0, K_SYS, '0, '0);
        acc('0, '1, SZ_WORD, 32'hE003_FFFC, '0, '0, K_SYS, '0, '0);
        acc('0, '0, SZ_WORD, 32'h0003_FFFC, '0, '0, K_CODE, '0, '0);
        acc('0, '0, SZ_BYTE, 32'h0000_0000, '0, '0, K_CODE, '0, '0);
        acc('0, '1, SZ_WORD, 32'h2004_0000, '1, '0, K_RSP, '1, '0);
        acc('0, '1, SZ_WORD, 32'h2000_0002, '1, '0, K_RSP, '1, '0);
        acc('0, '1, 2'h3, 32'h2000_0000, '1, '0, K_RSP, '1, '0);
        acc('0, '0, SZ_WORD, 32'h2000_0000, '0, '0, K_RSP, '0, '0);
        fin("decode");
        isram_en = 1'b0;
        cache_en = 1'b0;
        parity_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            acc(i[0], '0, SZ_WORD, WADR[i], '0, '0, K_RSP, '0, '0);
        end
        par_clr = 1'b1;
        fin("parity");
        check(32'(par_flag), 32'h0000_0000);
        check(32'(notes.size()), 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
